/* rtl/record_path_map.svh */
// Register indices, field positions, reset values and constants.
`ifndef RECORD_PATH_MAP_SVH
`define RECORD_PATH_MAP_SVH
`define SAMPLE_W 24
`define GAIN_W 10
`define FIFO_DEPTH 8
`define PLL_IDX 16'h4002
`define JACK_IDX 16'h4008
`define LDIFF_IDX 16'h400E
`define RDIFF_IDX 16'h400F
`define BIAS_IDX 16'h4010
`define ALC0_IDX 16'h4011
`define ALC1_IDX 16'h4012
`define ALC2_IDX 16'h4013
`define ALC3_IDX 16'h4014
`define CONV0_IDX 16'h4017
`define ADCCTL_IDX 16'h4019
`define LVOL_IDX 16'h401A
`define RVOL_IDX 16'h401B
`define PLL_RST 16'h1000
`define PLL_INT_12M288 16'h2001
`define PLL_INT_24M576 16'h1001
`define DIFF_RST 8'h00
`define ADCCTL_RST 8'h23
`define ZERO8 8'h00
`define JACK_FUNC_LSB 4
`define JACK_FUNC_DMIC 2'h2
`define DIFF_EN_BIT 0
`define BIAS_EN_BIT 0
`define BIAS_BOOST_BIT 2
`define BIAS_HP_BIT 3
`define OSR_BIT 3
`define ADC_LEN_BIT 0
`define ADC_REN_BIT 1
`define DMIC_SEL_BIT 2
`define HPF_EN_BIT 5
`define HPF_SHIFT 12
`define HPF_ACC_W 36
`define HOLD_CNT_W 16
`endif

/* rtl/record_path_pkg.sv */
// Types shared by the record path control logic.
package record_path_pkg;
	typedef logic signed [23:0] sample_type;
	typedef struct packed {
		sample_type left;
		sample_type right;
	} stereo_sample_type;
	typedef enum logic [2:0] {
		alc_off = 3'b000,
		alc_right = 3'b001,
		alc_left = 3'b010,
		alc_stereo = 3'b011
	} alc_mode_type;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_attack = 2'b01,
		st_hold = 2'b10,
		st_decay = 2'b11
	} alc_state_type;
endpackage

/* rtl/record_path_alc_control.sv */
// Record path control: registers, input select, filtering, level control.
// How it works
// - Integer PLL at 48 kHz: 12.288 MHz uses integer 4, 24.576 MHz 2.
// - Bit 0 of each differential volume register enables that channel's PROGRAMMABLE_INPUT_AMPLIFIER.
// - Jack pin function code 10 disables detection; with ADC control bit 2 set it also enables digital mic.
// - Digital mic in use forces serial port master, bit clock feeds mic.
// - Input select feeds mic or ADC samples to decimation, never both.
// - ADC samples are 24-bit; converter bit 3 picks 64 or 128 oversampling.
// - Each channel is attenuated by its own digital volume register.
// - DC blocking high-pass is on after reset and can be switched off.
// - Level control measures ADC output and steers PROGRAMMABLE_INPUT_AMPLIFIER gain continuously.
// - Level control moves gain in fine steps, one per sample.
// - Level control acts only on channels whose differential PROGRAMMABLE_INPUT_AMPLIFIER is on.
// - Level control settings live in registers 0x4011 through 0x4014.
// - Select field picks left, right or stereo; stereo uses larger level.
// - Four-bit target sets the level the control aims for.
// - Bias register gives enable, high performance and 0.65/0.90 boost.
// - Gain rises only after level stays below target for the hold time.
`timescale 1ns/1ps
`include "record_path_map.svh"

// ----------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------
module sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready_o = count_reg != DEPTH[AW:0];
	assign out_valid_o = count_reg != '0;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem[rd_ptr_reg];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			end
			if (push & ~pop) begin
				count_reg <= (AW+1)'(count_reg + 1'b1);
			end else if (pop & ~push) begin
				count_reg <= (AW+1)'(count_reg - 1'b1);
			end
		end
	end
endmodule

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module record_path_alc_control (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic adc_valid_i,
	output logic adc_ready_o,
	input wire record_path_pkg::stereo_sample_type adc_data_i,
	input wire logic dmic_valid_i,
	output logic dmic_ready_o,
	input wire record_path_pkg::stereo_sample_type dmic_data_i,
	output logic rec_valid_o,
	input wire logic rec_ready_i,
	output record_path_pkg::stereo_sample_type rec_data_o,
	output logic [`GAIN_W-1:0] left_pga_gain_o,
	output logic [`GAIN_W-1:0] right_pga_gain_o,
	output logic left_diff_amp_enable_o,
	output logic right_diff_amp_enable_o,
	output logic jack_detect_enable_o,
	output logic digital_mic_active_o,
	output logic serial_port_master_o,
	output logic oversample_128_o,
	output logic left_adc_enable_o,
	output logic right_adc_enable_o,
	output logic mic_bias_enable_o,
	output logic mic_bias_boost_o,
	output logic mic_bias_high_perf_o,
	output logic [1:0] pll_input_divider_o,
	output logic [3:0] pll_integer_o,
	output logic pll_fractional_o,
	output logic pll_enable_o
);
	// --------------------------------------------------------------
	// Functions
	// --------------------------------------------------------------
	function automatic logic [22:0] magnitude(input logic [23:0] s);
		magnitude = s[23] ? 23'(~s + 24'h000001) : s[22:0];
	endfunction

	function automatic logic [23:0] attenuate(input logic [23:0] s,
		input logic [7:0] vol);
		logic signed [33:0] p;
		p = $signed(s) * $signed({1'b0, 9'h100 - {1'b0, vol}});
		attenuate = p[31:8];
	endfunction

	// --------------------------------------------------------------
	// Register bus
	// --------------------------------------------------------------
	logic [15:0] pll_reg;
	logic [7:0] jack_reg, ldiff_reg, rdiff_reg, bias_reg;
	logic [7:0] alc_reg [4];
	logic [7:0] conv0_reg, adcctl_reg, lvol_reg, rvol_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic [15:0] idx;
	logic wr;
	logic [31:0] rd_next;

	assign idx = adr_i[17:2];
	assign wr = cyc_i & stb_i & we_i & ~ack_reg;
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	always_comb begin
		rd_next = 32'h00000000;
		case (idx)
			`PLL_IDX: rd_next[15:0] = pll_reg;
			`JACK_IDX: rd_next[7:0] = jack_reg;
			`LDIFF_IDX: rd_next[7:0] = ldiff_reg;
			`RDIFF_IDX: rd_next[7:0] = rdiff_reg;
			`BIAS_IDX: rd_next[7:0] = bias_reg;
			`ALC0_IDX: rd_next[7:0] = alc_reg[0];
			`ALC1_IDX: rd_next[7:0] = alc_reg[1];
			`ALC2_IDX: rd_next[7:0] = alc_reg[2];
			`ALC3_IDX: rd_next[7:0] = alc_reg[3];
			`CONV0_IDX: rd_next[7:0] = conv0_reg;
			`ADCCTL_IDX: rd_next[7:0] = adcctl_reg;
			`LVOL_IDX: rd_next[7:0] = lvol_reg;
			`RVOL_IDX: rd_next[7:0] = rvol_reg;
			default: rd_next = 32'h00000000;
		endcase
		if (idx == `ALC3_IDX + 16'h0001) begin
			rd_next[`GAIN_W-1:0] = left_pga_gain_o;
			rd_next[`GAIN_W+15:16] = right_pga_gain_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			ack_reg <= cyc_i & stb_i & ~ack_reg;
			if (cyc_i & stb_i & ~we_i & ~ack_reg) begin
				dat_reg <= rd_next;
			end
		end
	end

	// Only lane 0 carries these 8-bit registers; lane 1 the PLL high byte.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_reg <= `PLL_RST;
			jack_reg <= `ZERO8;
			ldiff_reg <= `DIFF_RST;
			rdiff_reg <= `DIFF_RST;
			bias_reg <= `ZERO8;
			conv0_reg <= `ZERO8;
			adcctl_reg <= `ADCCTL_RST;
			lvol_reg <= `ZERO8;
			rvol_reg <= `ZERO8;
			for (int i = 0; i < 4; i++) begin
				alc_reg[i] <= `ZERO8;
			end
		end else if (wr & sel_i[0]) begin
			case (idx)
				`PLL_IDX: pll_reg[7:0] <= dat_i[7:0];
				`JACK_IDX: jack_reg <= dat_i[7:0];
				`LDIFF_IDX: ldiff_reg <= dat_i[7:0];
				`RDIFF_IDX: rdiff_reg <= dat_i[7:0];
				`BIAS_IDX: bias_reg <= dat_i[7:0];
				`ALC0_IDX: alc_reg[0] <= dat_i[7:0];
				`ALC1_IDX: alc_reg[1] <= dat_i[7:0];
				`ALC2_IDX: alc_reg[2] <= dat_i[7:0];
				`ALC3_IDX: alc_reg[3] <= dat_i[7:0];
				`CONV0_IDX: conv0_reg <= dat_i[7:0];
				`ADCCTL_IDX: adcctl_reg <= dat_i[7:0];
				`LVOL_IDX: lvol_reg <= dat_i[7:0];
				`RVOL_IDX: rvol_reg <= dat_i[7:0];
				default: ;
			endcase
		end
		if (!rst_i && wr && sel_i[1] && idx == `PLL_IDX) begin
			pll_reg[15:8] <= dat_i[15:8];
		end
	end

	// --------------------------------------------------------------
	// Static controls
	// --------------------------------------------------------------
	logic dmic_pin, dmic_on, hpf_on;

	// Fraction terms are not held: integer mode ignores them.
	assign pll_input_divider_o = pll_reg[10:9];
	assign pll_integer_o = pll_reg[14:11];
	assign pll_fractional_o = pll_reg[8];
	assign pll_enable_o = pll_reg[0];
	assign left_diff_amp_enable_o = ldiff_reg[`DIFF_EN_BIT];
	assign right_diff_amp_enable_o = rdiff_reg[`DIFF_EN_BIT];
	assign dmic_pin = jack_reg[`JACK_FUNC_LSB+1:`JACK_FUNC_LSB] ==
		`JACK_FUNC_DMIC;
	assign jack_detect_enable_o = ~dmic_pin;
	assign dmic_on = dmic_pin & adcctl_reg[`DMIC_SEL_BIT];
	assign digital_mic_active_o = dmic_on;
	assign serial_port_master_o = dmic_on;
	assign oversample_128_o = conv0_reg[`OSR_BIT];
	assign left_adc_enable_o = adcctl_reg[`ADC_LEN_BIT];
	assign right_adc_enable_o = adcctl_reg[`ADC_REN_BIT];
	assign hpf_on = adcctl_reg[`HPF_EN_BIT];
	assign mic_bias_enable_o = bias_reg[`BIAS_EN_BIT];
	assign mic_bias_boost_o = bias_reg[`BIAS_BOOST_BIT];
	assign mic_bias_high_perf_o = bias_reg[`BIAS_HP_BIT];

	// --------------------------------------------------------------
	// Sample path
	// --------------------------------------------------------------
	record_path_pkg::stereo_sample_type src, filt, out_s;
	logic src_valid, fifo_ready, take;
	logic signed [`HPF_ACC_W-1:0] lacc_reg, racc_reg;

	// The shared decimator sees exactly one source at a time.
	assign src = dmic_on ? dmic_data_i : adc_data_i;
	assign src_valid = dmic_on ? dmic_valid_i : adc_valid_i;
	assign adc_ready_o = fifo_ready & ~dmic_on;
	assign dmic_ready_o = fifo_ready & dmic_on;
	assign take = src_valid & fifo_ready;

	// First-order DC blocker; shift 12 puts the corner near 2 Hz at 48 kHz.
	assign filt.left = hpf_on ? 24'(src.left - lacc_reg[35:12]) : src.left;
	assign filt.right = hpf_on ? 24'(src.right - racc_reg[35:12]) :
		src.right;
	assign out_s.left = attenuate(filt.left, lvol_reg);
	assign out_s.right = attenuate(filt.right, rvol_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i || !hpf_on) begin
			lacc_reg <= '0;
			racc_reg <= '0;
		end else if (take) begin
			lacc_reg <= lacc_reg + `HPF_ACC_W'(filt.left);
			racc_reg <= racc_reg + `HPF_ACC_W'(filt.right);
		end
	end

	sample_fifo #(
		.WIDTH(2 * `SAMPLE_W),
		.DEPTH(`FIFO_DEPTH)
	) fifo_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(src_valid),
		.in_ready_o(fifo_ready),
		.in_data_i(out_s),
		.out_valid_o(rec_valid_o),
		.out_ready_i(rec_ready_i),
		.out_data_o(rec_data_o)
	);

	// --------------------------------------------------------------
	// Level control
	// --------------------------------------------------------------
	record_path_pkg::alc_mode_type mode;
	record_path_pkg::alc_state_type state_reg, state_next;
	logic [3:0] target;
	logic [3:0] hold_sel;
	logic [`GAIN_W-1:0] gain_max;
	logic [`GAIN_W-1:0] gain_reg;
	logic [`HOLD_CNT_W-1:0] hold_cnt_reg;
	logic [`HOLD_CNT_W-1:0] hold_len;
	logic [22:0] lmag, rmag, level;
	logic alc_on, over, l_alc, r_alc;

	assign mode = record_path_pkg::alc_mode_type'(alc_reg[0][2:0]);
	assign gain_max = {alc_reg[0][5:3], 7'h7F};
	assign target = alc_reg[1][3:0];
	assign hold_sel = alc_reg[2][7:4];
	assign hold_len = `HOLD_CNT_W'(1) << hold_sel;
	assign lmag = magnitude(filt.left);
	assign rmag = magnitude(filt.right);
	always_comb begin
		case (mode)
			record_path_pkg::alc_left: level = lmag;
			record_path_pkg::alc_right: level = rmag;
			record_path_pkg::alc_stereo: level = lmag > rmag ? lmag :
				rmag;
			default: level = 23'h000000;
		endcase
	end
	assign alc_on = mode == record_path_pkg::alc_left ||
		mode == record_path_pkg::alc_right ||
		mode == record_path_pkg::alc_stereo;
	assign over = level[22:19] > target;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			record_path_pkg::st_idle:
				state_next = over ? record_path_pkg::st_attack :
					record_path_pkg::st_hold;
			record_path_pkg::st_attack:
				if (!over) begin
					state_next = record_path_pkg::st_hold;
				end
			record_path_pkg::st_hold:
				if (over) begin
					state_next = record_path_pkg::st_attack;
				end else if (hold_cnt_reg >= hold_len) begin
					state_next = record_path_pkg::st_decay;
				end
			record_path_pkg::st_decay:
				if (over) begin
					state_next = record_path_pkg::st_attack;
				end
			default: state_next = record_path_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !alc_on) begin
			state_reg <= record_path_pkg::st_idle;
			hold_cnt_reg <= '0;
		end else if (take && !dmic_on) begin
			state_reg <= state_next;
			if (state_next == record_path_pkg::st_hold) begin
				hold_cnt_reg <= `HOLD_CNT_W'(hold_cnt_reg + 1'b1);
			end else begin
				hold_cnt_reg <= '0;
			end
		end
	end

	// Gain starts from the left volume setting so enabling is click free for the left channel.
	always_ff @(posedge clk_i) begin
		if (rst_i || !alc_on) begin
			gain_reg <= {ldiff_reg[7:2], 4'h0};
		end else if (take && !dmic_on) begin
			if (state_reg == record_path_pkg::st_attack &&
				gain_reg != '0) begin
				gain_reg <= `GAIN_W'(gain_reg - 1'b1);
			end else if (state_reg == record_path_pkg::st_decay &&
				gain_reg < gain_max) begin
				gain_reg <= `GAIN_W'(gain_reg + 1'b1);
			end
		end
	end

	assign l_alc = alc_on && mode != record_path_pkg::alc_right &&
		left_diff_amp_enable_o;
	assign r_alc = alc_on && mode != record_path_pkg::alc_left &&
		right_diff_amp_enable_o;
	assign left_pga_gain_o = l_alc ? gain_reg :
		{ldiff_reg[7:2], 4'h0};
	assign right_pga_gain_o = r_alc ? gain_reg :
		{rdiff_reg[7:2], 4'h0};
endmodule

/* dv/sample_source_model.sv */
// Source model for the converter and digital microphone sample streams.
`timescale 1ns/1ps

module sample_source_model (
	input wire logic clk_i,
	input wire logic ready_i,
	output logic valid_o,
	output record_path_pkg::stereo_sample_type data_o
);
	initial begin
		valid_o = 1'b0;
		data_o = '0;
	end

	// A sample is held until ready is seen at an edge. Released data shows
	// the inverse so that a stale word can never pass for a fresh one.
	task automatic send(input record_path_pkg::stereo_sample_type s);
		valid_o <= 1'b1;
		data_o <= s;
		do @(posedge clk_i); while (ready_i !== 1'b1);
		valid_o <= 1'b0;
		data_o <= ~s;
		@(posedge clk_i);
	endtask
endmodule

/* dv/record_path_alc_control_monitor.sv */
// Concurrent checks on the ports of the record path control block.
`timescale 1ns/1ps
`include "record_path_map.svh"

module record_path_alc_control_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire logic adc_valid_i,
	input wire logic adc_ready_o,
	input wire logic dmic_ready_o,
	input wire logic rec_valid_o,
	input wire logic rec_ready_i,
	input wire record_path_pkg::stereo_sample_type rec_data_o,
	input wire logic [9:0] left_pga_gain_o,
	input wire logic left_diff_amp_enable_o,
	input wire logic jack_detect_enable_o,
	input wire logic digital_mic_active_o,
	input wire logic serial_port_master_o,
	input wire logic mic_bias_enable_o
);
	logic wr;
	logic [15:0] idx;
	assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
	assign idx = adr_i[17:2];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	chk_bus_answer: assert property (
		cyc_i && stb_i && !ack_o |=> ack_o) else $error("no bus answer");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_diff_write: assert property (
		wr && idx == `LDIFF_IDX |=> left_diff_amp_enable_o == $past(dat_i[0]))
		else $error("amp enable misses write");
	chk_jack_off_mic: assert property (
		digital_mic_active_o |-> !jack_detect_enable_o)
		else $error("jack detect on with mic");
	chk_mic_master: assert property (
		serial_port_master_o == digital_mic_active_o)
		else $error("port master differs from mic use");
	chk_one_source: assert property (
		digital_mic_active_o ? !adc_ready_o : !dmic_ready_o)
		else $error("both sample sources open");
	chk_gain_fine: assert property (
		!ack_o |-> 10'(left_pga_gain_o - $past(left_pga_gain_o))
		inside {10'h000, 10'h001, 10'h3FF}) else $error("coarse gain step");
	chk_bias_write: assert property (
		wr && idx == `BIAS_IDX |=> mic_bias_enable_o == $past(dat_i[0]))
		else $error("bias enable misses write");
	chk_sample_lat: assert property (
		adc_valid_i && adc_ready_o |=> rec_valid_o)
		else $error("sample not visible next cycle");
	chk_rec_held: assert property (
		rec_valid_o && !rec_ready_i |=> rec_valid_o && $stable(rec_data_o))
		else $error("output word not held");
	cover property (wr && idx == `LDIFF_IDX);
	cover property (digital_mic_active_o && dmic_ready_o);
	cover property (!adc_ready_o && !digital_mic_active_o);
	cover property (left_pga_gain_o != $past(left_pga_gain_o) && !ack_o);
endmodule

bind record_path_alc_control record_path_alc_control_monitor i_mon (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.ack_o(ack_o), .adc_valid_i(adc_valid_i), .adc_ready_o(adc_ready_o),
	.dmic_ready_o(dmic_ready_o), .rec_valid_o(rec_valid_o),
	.rec_ready_i(rec_ready_i), .rec_data_o(rec_data_o),
	.left_pga_gain_o(left_pga_gain_o),
	.left_diff_amp_enable_o(left_diff_amp_enable_o),
	.jack_detect_enable_o(jack_detect_enable_o),
	.digital_mic_active_o(digital_mic_active_o),
	.serial_port_master_o(serial_port_master_o),
	.mic_bias_enable_o(mic_bias_enable_o));

/* dv/record_path_alc_control_tb_top.sv */
// Self-checking bench for the record path control block.
`timescale 1ns/1ps
`include "record_path_map.svh"

module record_path_alc_control_tb_top;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, stall;
	logic [31:0] adr_i, dat_i, dat_o;
	logic [3:0] sel_i, pint;
	logic adc_valid_i, adc_ready_o, dmic_valid_i, dmic_ready_o;
	logic rec_valid_o, rec_ready_i, lde, rde, jde, dma, spm, o128;
	logic mbe, mbb, mbh, pfr, lae, rae, pen;
	logic [1:0] pdiv;
	logic [9:0] lg, rg;
	record_path_pkg::stereo_sample_type adc_data_i, dmic_data_i, rec_data_o;
	int fail_count, samples_checked, cycles, seed;
	logic [47:0] sq[$];
	logic [31:0] rq[$];
	logic [15:0] ri [12] = '{`PLL_IDX, `JACK_IDX, `LDIFF_IDX, `RDIFF_IDX,
		`BIAS_IDX, `ALC0_IDX, `CONV0_IDX, `ADCCTL_IDX, `LVOL_IDX,
		`RVOL_IDX, `ALC3_IDX, 16'h4030};
	logic [7:0] av [4] = '{8'h38, 8'h05, 8'h20, 8'h5A};

	record_path_alc_control i_record_path_alc_control (.clk_i(clk_i),
		.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .adc_valid_i(adc_valid_i), .adc_ready_o(adc_ready_o),
		.adc_data_i(adc_data_i), .dmic_valid_i(dmic_valid_i),
		.dmic_ready_o(dmic_ready_o), .dmic_data_i(dmic_data_i),
		.rec_valid_o(rec_valid_o), .rec_ready_i(rec_ready_i),
		.rec_data_o(rec_data_o), .left_pga_gain_o(lg), .right_pga_gain_o(rg),
		.left_diff_amp_enable_o(lde), .right_diff_amp_enable_o(rde),
		.jack_detect_enable_o(jde), .digital_mic_active_o(dma),
		.serial_port_master_o(spm), .oversample_128_o(o128),
		.left_adc_enable_o(lae), .right_adc_enable_o(rae),
		.mic_bias_enable_o(mbe), .mic_bias_boost_o(mbb),
		.mic_bias_high_perf_o(mbh), .pll_input_divider_o(pdiv),
		.pll_integer_o(pint), .pll_fractional_o(pfr), .pll_enable_o(pen));
	sample_source_model i_adc (.clk_i(clk_i), .ready_i(adc_ready_o),
		.valid_o(adc_valid_i), .data_o(adc_data_i));
	sample_source_model i_dmic (.clk_i(clk_i), .ready_i(dmic_ready_o),
		.valid_o(dmic_valid_i), .data_o(dmic_data_i));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic ck(input string n, input logic [47:0] s, e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [15:0] a,
		input logic [31:0] d, input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {14'h0, a, 2'h0};
		dat_i <= d;
		sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'h1);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0, 4'hF);
	endtask
	// Linear attenuation with an arithmetic shift, as the volume law reads.
	function automatic logic [23:0] att(input logic signed [23:0] s,
		input logic [7:0] v);
		longint p;
		p = longint'(s) * (longint'(256) - longint'(v));
		return 24'(p >>> 8);
	endfunction
	task automatic smp(input logic d, input logic [23:0] l, r,
		input logic [7:0] lv, rv);
		sq.push_back({att(l, lv), att(r, rv)});
		if (d) i_dmic.send({l, r});
		else i_adc.send({l, r});
	endtask
	task automatic gck(input logic [9:0] l, r);
		repeat (3) @(posedge clk_i);
		ck("left gain", 48'(lg), 48'(l));
		ck("right gain", 48'(rg), 48'(r));
	endtask
	task automatic drain;
		for (int i = 0; i < 400 && sq.size() > 0; i++) @(posedge clk_i);
		@(posedge clk_i);
	endtask

	// ------------------------------------------------------------------
	// Clock, far-side stalls, watcher and timeout
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		rec_ready_i <= stall ? 1'b0 : 1'($random(seed));
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end
	always @(posedge clk_i) begin
		if (rec_valid_o === 1'b1 && rec_ready_i)
			ck("rec", rec_data_o, sq.pop_front());
		if (ack_o === 1'b1 && !we_i)
			ck("read", 48'(dat_o), 48'(rq.pop_front()));
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		seed = 32'h068D;
		{cyc_i, stb_i, we_i, stall, rec_ready_i, cycles} = '0;
		{adr_i, dat_i, sel_i, fail_count, samples_checked} = '0;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 12; i++)
			rd(ri[i], i == 0 ? 32'h1000 : i == 7 ? 32'h23 : 32'h0);
		ck("pll int", 48'(pint), 48'h2);
		wr(16'h4030, 32'hFF);
		rd(16'h4030, 32'h0);
		smp(1'b0, 24'h100000, 24'h100000, 8'h0, 8'h0);
		sq.push_back({2{24'h0FFF00}});
		i_adc.send({2{24'h100000}});
		wr(`ADCCTL_IDX, 32'h03);
		ck("adc en", 48'({lae, rae}), 48'h3);
		wr(`LVOL_IDX, 32'h40);
		wr(`RVOL_IDX, 32'hC0);
		repeat (6) smp(1'b0, 24'($random(seed)), 24'($random(seed)),
			8'h40, 8'hC0);
		wr(`LVOL_IDX, 32'h0);
		wr(`RVOL_IDX, 32'h0);
		drain();
		stall <= 1'b1;
		@(posedge clk_i);
		repeat (8) smp(1'b0, 24'($random(seed)), 24'h0, 8'h0, 8'h0);
		ck("fifo full", 48'(adc_ready_o), 48'h0);
		stall <= 1'b0;
		drain();
		ck("fifo empty", 48'(rec_valid_o), 48'h0);
		for (int v = 0; v < 2; v++) begin
			wr(`LDIFF_IDX, 32'(v));
			wr(`RDIFF_IDX, 32'(v));
			ck("diff", 48'({lde, rde}), 48'({v[0], v[0]}));
			wr(`CONV0_IDX, 32'(v) << 3);
			ck("osr", 48'(o128), 48'(v[0]));
		end
		for (int v = 0; v < 8; v++) begin
			wr(`BIAS_IDX, {28'h0, v[2], v[1], 1'b0, v[0]});
			ck("bias", 48'({mbh, mbb, mbe}), 48'(v[2:0]));
		end
		wb(1'b1, `PLL_IDX, 32'h1001, 4'h3);
		ck("pll", 48'({pint, pdiv, pfr}), 48'({4'h2, 2'h0, 1'b0}));
		ck("pll en", 48'(pen), 48'h1);
		wb(1'b1, `PLL_IDX, 32'h2001, 4'h3);
		ck("pll", 48'({pint, pdiv, pfr}), 48'({4'h4, 2'h0, 1'b0}));
		for (int i = 0; i < 4; i++) begin
			wr(`ALC0_IDX + 16'(i), 32'(av[i]));
			rd(`ALC0_IDX + 16'(i), 32'(av[i]));
		end
		wr(`ADCCTL_IDX, 32'h07);
		for (int c = 0; c < 4; c++) begin
			wr(`JACK_IDX, 32'(c) << 4);
			ck("jack", 48'(jde), 48'(c != 2));
			ck("mic", 48'({dma, spm}), 48'({2{c == 2}}));
			ck("adc open", 48'(adc_ready_o), 48'(c != 2));
			if (c == 2) smp(1'b1, 24'h012345, 24'hFEDCBA, 8'h0, 8'h0);
		end
		wr(`JACK_IDX, 32'h0);
		wr(`ADCCTL_IDX, 32'h03);
		wr(`LDIFF_IDX, 32'hFD);
		wr(`RDIFF_IDX, 32'h85);
		gck(10'h3F0, 10'h210);
		wr(`LDIFF_IDX, 32'h81);
		wr(`ALC1_IDX, 32'h0);
		wr(`ALC0_IDX, 32'h3A);
		repeat (5) smp(1'b0, 24'h7FFFFF, 24'h0, 8'h0, 8'h0);
		gck(10'h1FC, 10'h210);
		repeat (3) smp(1'b0, 24'h0, 24'h0, 8'h0, 8'h0);
		gck(10'h1FB, 10'h210);
		repeat (6) smp(1'b0, 24'h0, 24'h0, 8'h0, 8'h0);
		repeat (3) @(posedge clk_i);
		ck("gain rise", 48'(lg > 10'h1FB && lg < 10'h202), 48'h1);
		wr(`LDIFF_IDX, 32'h80);
		smp(1'b0, 24'h7FFFFF, 24'h0, 8'h0, 8'h0);
		gck(10'h200, 10'h210);
		wr(`ALC0_IDX, 32'h38);
		wr(`LDIFF_IDX, 32'h81);
		wr(`RDIFF_IDX, 32'h81);
		wr(`ALC0_IDX, 32'h3B);
		repeat (3) smp(1'b0, 24'h0, 24'h7FFFFF, 8'h0, 8'h0);
		gck(10'h1FE, 10'h1FE);
		wr(`ALC1_IDX, 32'h0F);
		repeat (2) smp(1'b0, 24'h0, 24'h7FFFFF, 8'h0, 8'h0);
		gck(10'h1FD, 10'h1FD);
		rd(`ALC3_IDX + 16'h0001, 32'h01FD01FD);
		wr(`ALC0_IDX, 32'h39);
		gck(10'h200, 10'h1FD);
		wr(`ALC0_IDX, 32'h38);
		drain();
		report_and_stop();
	end
endmodule
